// File: design/pga_consts.vh
// Constants for the packet line-access interpreter.
// Assumes inclusion by pga_*.v files only.
`ifndef PGA_CONSTS_VH
`define PGA_CONSTS_VH
`define PGA_OP_WRITE 8'h10
`define PGA_IF_LINES 8'h08
`define PGA_IF_MASK 8'h0F
`define PGA_ST_DONE 8'h20
`define PGA_ST_IFERR 8'h40
`define PGA_ST_REQERR 8'h80
`define PGA_LEN_LINES 8'h01
`define PGA_PKT_BYTES 3'h5
`define PGA_LINE_MASK 8'h7F
`define PGA_LINES_RST 7'h00
`endif

// File: design/pga_decode.v
// Decoder for the first request byte.
// Assumes a byte already captured in a flop.
`timescale 1ns/1ps
`include "pga_consts.vh"
module pga_decode (
   // Request byte
   input wire [7:0] head,
   // Decode results
   output wire is_line,
   output wire is_write,
   output wire is_valid
);
   wire [7:0] iface;
   assign iface = head & ~`PGA_OP_WRITE;
   // Only op flag plus one of the defined interface codes is legal
   assign is_valid = (iface == `PGA_IF_LINES) || (iface <= 8'h04 &&
      iface != 8'h03);
   assign is_line = (iface == `PGA_IF_LINES);
   assign is_write = (head & `PGA_OP_WRITE) != 8'h00;
endmodule // pga_decode

// File: design/pga_top.v
// Packet line-access interpreter: byte stream in, echo packet out.
// Assumes request bytes arrive as valid-qualified bytes, one per clock.
//
// Function
// - Interface code 0x08 selects line handler
// - Seven lines accessed as one byte
// - Bit 7 unused, bits 6..0 lines
// - Bytes 1 and 3 ignored for lines
// - Write drives lines from fifth byte
// - Read of four or more bytes returns line levels in fifth byte
// - Success reply ORs done, echoes bytes 1-3
// - First byte is op flag OR interface
// - Bad first byte replies with error flag
`timescale 1ns/1ps
`include "pga_consts.vh"
module pga_top (
   // Clock and reset
   input wire ref_clk,
   input wire nrst,
   // Request stream
   input wire req_valid,
   input wire [7:0] req_byte,
   input wire req_last,
   // Reply stream
   output wire rsp_valid,
   output wire [7:0] rsp_byte,
   output wire rsp_last,
   input wire rsp_ready,
   // Line levels in and drive out
   input wire [6:0] line_in,
   output wire gen_line_6,
   output wire gen_line_5,
   output wire gen_line_4,
   output wire gen_line_3,
   output wire gen_line_2,
   output wire gen_line_1,
   output wire gen_line_0,
   // Other interfaces are served elsewhere
   output wire fwd_req
);
   // One-hot states of the packet sequencer
   localparam S_RX = 4'b0001;
   localparam S_LOAD = 4'b0010;
   localparam S_TX = 4'b0100;
   localparam S_FWD = 4'b1000;

   // Reset release flops
   reg rst_a_q;
   reg rst_b_q;
   wire rst_n;
   // Sequencer state
   reg [3:0] state_q;
   reg [3:0] state_d;
   reg [2:0] idx_q;
   reg [2:0] idx_d;
   reg [2:0] len_q;
   reg [2:0] len_d;
   wire [2:0] nxt_idx;
   // Stored request packet
   reg [7:0] pkt_q [0:4];
   // Driven line levels
   reg [6:0] lines_q;
   reg [6:0] lines_d;
   // Reply byte register
   reg [7:0] rsp_byte_q;
   reg [7:0] rsp_byte_d;
   // Head byte decode
   wire is_line;
   wire is_write;
   wire is_valid;
   integer i;

   // Release reset through two flops
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_a_q <= 1'b0;
         rst_b_q <= 1'b0;
      end else begin
         rst_a_q <= 1'b1;
         rst_b_q <= rst_a_q;
      end
   end
   assign rst_n = rst_b_q;

   pga_decode u_dec (
      .head(pkt_q[0]),
      .is_line(is_line),
      .is_write(is_write),
      .is_valid(is_valid)
   );

   // Valid line-read request: fifth reply byte carries levels
   function line_read;
      input valid;
      input line;
      input write;
      begin
         line_read = valid && line && !write;
      end
   endfunction

   // Reply byte k built from stored byte b; every dependency is an
   // argument so that a caller in a combinational process sees it
   function [7:0] reply_byte;
      input [2:0] k;
      input [7:0] b;
      input valid;
      input line;
      input write;
      input [6:0] lvl;
      begin
         if (k == 3'd0) begin
            if (!valid)
               reply_byte = b | `PGA_ST_REQERR;
            else
               reply_byte = b | `PGA_ST_DONE;
         end else if (k == 3'd4 && line_read(valid, line, write)) begin
            reply_byte = {1'b0, lvl};
         end else begin
            reply_byte = b;
         end
      end
   endfunction

   assign nxt_idx = idx_q + 3'd1;

   always @* begin
      state_d = state_q;
      idx_d = idx_q;
      len_d = len_q;
      lines_d = lines_q;
      rsp_byte_d = rsp_byte_q;
      case (state_q)
         S_RX: begin
            if (req_valid) begin
               idx_d = nxt_idx;
               // Packet ends at its last byte or at the size limit
               if (req_last || idx_q == `PGA_PKT_BYTES - 3'd1) begin
                  len_d = nxt_idx;
                  idx_d = 3'd0;
                  state_d = S_LOAD;
               end
            end
         end
         S_LOAD: begin
            // Whole packet stored; head decode is settled here
            if (is_valid && !is_line) begin
               state_d = S_FWD;
            end else begin
               // A read of four or more bytes always answers five
               if (line_read(is_valid, is_line, is_write) &&
                   len_q >= 3'd4)
                  len_d = `PGA_PKT_BYTES;
               rsp_byte_d = reply_byte(3'd0, pkt_q[0], is_valid, is_line,
                  is_write, line_in);
               state_d = S_TX;
            end
         end
         S_TX: begin
            if (rsp_ready) begin
               // Lines change as the head reply byte is taken
               // Bit 7 of the written data is dropped here
               if (idx_q == 3'd0 && is_valid && is_line && is_write &&
                   len_q == `PGA_PKT_BYTES)
                  lines_d = pkt_q[4][6:0];
               if (idx_q == len_q - 3'd1) begin
                  idx_d = 3'd0;
                  state_d = S_RX;
               end else begin
                  // Next reply byte is prepared as this one is taken
                  idx_d = nxt_idx;
                  rsp_byte_d = reply_byte(nxt_idx, pkt_q[nxt_idx], is_valid,
                     is_line, is_write, line_in);
               end
            end
         end
         S_FWD: begin
            idx_d = 3'd0;
            state_d = S_RX;
         end
         default: begin
            idx_d = 3'd0;
            state_d = S_RX;
         end
      endcase
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_RX;
         idx_q <= 3'd0;
         len_q <= 3'd0;
         lines_q <= `PGA_LINES_RST;
         rsp_byte_q <= 8'h00;
         for (i = 0; i < `PGA_PKT_BYTES; i = i + 1)
            pkt_q[i] <= 8'h00;
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
         len_q <= len_d;
         lines_q <= lines_d;
         // Reply byte stands until the sink takes it
         rsp_byte_q <= rsp_byte_d;
         // Bytes offered outside the receive state are dropped
         if (state_q == S_RX && req_valid)
            pkt_q[idx_q] <= req_byte;
      end
   end

   // Handshake outputs decode the state flops
   assign rsp_valid = (state_q == S_TX);
   assign rsp_byte = rsp_byte_q;
   assign rsp_last = rsp_valid && (idx_q == len_q - 3'd1);
   // One-cycle pulse hands other interfaces elsewhere
   assign fwd_req = (state_q == S_FWD);
   assign {gen_line_6, gen_line_5, gen_line_4, gen_line_3,
      gen_line_2, gen_line_1, gen_line_0} = lines_q;
endmodule // pga_top

// File: tb/pga_host.sv
// Host model; assumes pga_top request and reply ports.
`timescale 1ns/1ps
module pga_host (
   input wire ref_clk, rsp_valid, rsp_last,
   input wire [7:0] rsp_byte,
   output reg req_valid = 1'b0, req_last = 1'b0, rsp_ready = 1'b0,
   output reg [7:0] req_byte = 8'h00
);
   task xfer(input [39:0] p, input [2:0] n, input slow,
      output [39:0] r, output [3:0] c, output [3:0] l);
      integer i;
      begin
         r = 40'h0;
         c = 4'h0;
         l = 4'h0;
         for (i = 0; i < n; i = i + 1) begin
            req_valid = 1'b1;
            req_byte = p[39 - 8 * i -: 8];
            req_last = i == n - 1;
            @(posedge ref_clk) #1;
         end
         req_valid = 1'b0;
         req_last = 1'b0;
         req_byte = ~req_byte;
         for (i = 0; i < 16 && c < 5; i = i + 1) begin
            rsp_ready = !slow || i[0];
            @(posedge ref_clk) if (rsp_valid && rsp_ready) begin
               r[39 - 8 * c -: 8] = rsp_byte;
               c = c + 4'h1;
               if (rsp_last)
                  l = c;
            end
            #1;
         end
         rsp_ready = 1'b0;
      end
   endtask
endmodule // pga_host

// File: tb/pga_properties.sv
// Port checker for pga_top; assumes packets closed by req_last.
`timescale 1ns/1ps
module pga_chk (
   input wire ref_clk, nrst, req_valid, req_last, rsp_ready, fwd_req,
   input wire rsp_valid, rsp_last, gen_line_6, gen_line_5, gen_line_4,
   input wire gen_line_3, gen_line_2, gen_line_1, gen_line_0,
   input wire [7:0] req_byte, rsp_byte,
   input wire [6:0] line_in
);
   reg f_q;
   reg [7:0] h_q;
   wire [6:0] ln = {gen_line_6, gen_line_5, gen_line_4, gen_line_3,
      gen_line_2, gen_line_1, gen_line_0};
   wire bad = h_q[7:5] != 3'h0 ||
      !(h_q[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8});
   always @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         f_q <= 1'b1;
         h_q <= 8'h00;
      end else if (req_valid) begin
         h_q <= f_q ? req_byte : h_q;
         f_q <= req_last;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence s_hd; $rose(rsp_valid); endsequence
   sequence s_tl; rsp_valid && rsp_last; endsequence
   a_done_echo: assert property (s_hd ##0 (h_q[3] && !bad) |->
      rsp_byte == (h_q | 8'h20)) else $error("done byte");
   a_req_error: assert property (s_hd ##0 bad |->
      rsp_byte == (h_q | 8'h80)) else $error("error byte");
   a_write_lines: assert property (s_tl ##0 (h_q == 8'h18) |->
      ln == rsp_byte[6:0]) else $error("lines");
   a_read_data: assert property (s_tl ##0 (h_q == 8'h08) |->
      rsp_byte == {1'b0, line_in}) else $error("read data");
   a_byte_stands: assert property (rsp_valid && !rsp_ready |=>
      rsp_valid && $stable(rsp_byte)) else $error("byte moved");
   a_fwd_code: assert property (fwd_req |-> !h_q[3] && !bad)
      else $error("forward");
   a_fwd_quiet: assert property (fwd_req |=> !rsp_valid [*2])
      else $error("reply");
   a_fwd_pulse: assert property (fwd_req |=> !fwd_req)
      else $error("forward pulse");
   a_lines_hold: assert property (!rsp_valid |=> $stable(ln))
      else $error("lines moved");
endmodule // pga_chk
bind pga_top pga_chk chk_u (
   .ref_clk(ref_clk),
   .nrst(nrst),
   .req_valid(req_valid),
   .req_last(req_last),
   .rsp_ready(rsp_ready),
   .fwd_req(fwd_req),
   .rsp_valid(rsp_valid),
   .rsp_last(rsp_last),
   .gen_line_6(gen_line_6),
   .gen_line_5(gen_line_5),
   .gen_line_4(gen_line_4),
   .gen_line_3(gen_line_3),
   .gen_line_2(gen_line_2),
   .gen_line_1(gen_line_1),
   .gen_line_0(gen_line_0),
   .req_byte(req_byte),
   .rsp_byte(rsp_byte),
   .line_in(line_in)
);

// File: tb/tb_top.sv
// Bench for pga_top; lines looped back to line_in.
`timescale 1ns/1ps
module tb_top;
   reg ref_clk = 1'b0, nrst = 1'b0;
   integer fails = 0, samples_checked = 0;
   reg [39:0] r;
   reg [3:0] c;
   reg [3:0] l;
   wire req_valid, req_last, rsp_valid, rsp_last, rsp_ready, fwd_req;
   wire gen_line_6, gen_line_5, gen_line_4, gen_line_3, gen_line_2;
   wire gen_line_1, gen_line_0;
   wire [7:0] req_byte, rsp_byte;
   wire [6:0] line_in = {gen_line_6, gen_line_5, gen_line_4, gen_line_3,
      gen_line_2, gen_line_1, gen_line_0};
   always #12.5 ref_clk = ~ref_clk;
   pga_top dut_u (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .req_valid(req_valid),
      .req_byte(req_byte),
      .req_last(req_last),
      .rsp_valid(rsp_valid),
      .rsp_byte(rsp_byte),
      .rsp_last(rsp_last),
      .rsp_ready(rsp_ready),
      .line_in(line_in),
      .gen_line_6(gen_line_6),
      .gen_line_5(gen_line_5),
      .gen_line_4(gen_line_4),
      .gen_line_3(gen_line_3),
      .gen_line_2(gen_line_2),
      .gen_line_1(gen_line_1),
      .gen_line_0(gen_line_0),
      .fwd_req(fwd_req)
   );
   pga_host h_u (
      .ref_clk(ref_clk),
      .rsp_valid(rsp_valid),
      .rsp_last(rsp_last),
      .rsp_byte(rsp_byte),
      .req_valid(req_valid),
      .req_last(req_last),
      .rsp_ready(rsp_ready),
      .req_byte(req_byte)
   );
   task chk(input [39:0] s, e);
      begin
         samples_checked = samples_checked + 1;
         if (s !== e) begin
            fails = fails + 1;
            $display("ERROR %0t saw %h want %h", $time, s, e);
         end
      end
   endtask
   task tally_and_finish;
      begin
         $display("fails %0d of %0d", fails, samples_checked);
         if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task t_line(input [7:0] d);
      begin
         h_u.xfer({32'h18A50155, d}, 3'd5, 1'b1, r, c, l);
         chk(r, {32'h38A50155, d});
         chk(l, 4'h5);
         chk(line_in, d[6:0]);
         h_u.xfer({32'h08AA0155, ~d}, 3'd5, 1'b0, r, c, l);
         chk(r, {32'h28AA0155, 1'b0, d[6:0]});
         h_u.xfer({32'h08000100, 8'h00}, 3'd4, 1'b0, r, c, l);
         chk(r, {32'h28000100, 1'b0, d[6:0]});
         chk(l, 4'h5);
      end
   endtask
   task t_other;
      begin
         h_u.xfer(40'h13A00205AA, 3'd5, 1'b0, r, c, l);
         chk(r, 40'h93A00205AA);
         chk(l, 4'h5);
         h_u.xfer(40'h11A00105AA, 3'd5, 1'b0, r, c, l);
         chk(c, 4'h0);
         chk(line_in, 7'h3F);
      end
   endtask
   initial begin
      repeat (20) @(posedge ref_clk);
      #1 nrst = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 t_line(8'hC0);
      t_line(8'h3F);
      t_other;
      tally_and_finish;
   end
   initial begin
      #50000 fails = fails + 1;
      tally_and_finish;
   end
endmodule // tb_top
